// file: rtl/ocp_pkg.sv
// How it works
// - With the start-up clock option on, the initialization count is timed by edges of startupClockIn.
// - In the active serial scheme with the clock source and start-up clock options set, configSerialClock follows startupClockIn.
// - Each optional pin is ordinary user I/O when its option is off and dedicated only when it is on.
// - While configRequestN is low the initialization-complete pin is left undriven.
// - Once the first frame has loaded the initialization-complete option, that pin is driven low.
// - At the end of initialization the pin is released, never driven high, and user mode begins.
// - With the calibration gating option on, release waits for terminationCalibrated; otherwise it does not.
// - With the output-enable option on and that input low, every user I/O is forced to high impedance.
// - With the output-enable input high, user I/O follows its programmed output enables.
// - With the clear option on and the clear input low, every register is cleared; high lets them run.
package ocp_pkg;

    // sequencer state, binary coded
    typedef enum logic [2:0] {
        OCP_IDLE    = 3'h0,
        OCP_LOAD    = 3'h1,
        OCP_CONFIG  = 3'h2,
        OCP_INIT    = 3'h3,
        OCP_CALWAIT = 3'h4,
        OCP_USER    = 3'h5
    } ocp_state_e;

    // option word handed over with the first configuration frame
    localparam int OPT_W            = 6;
    localparam int OPT_STARTUP_CLK  = 0;
    localparam int OPT_INIT_DONE    = 1;
    localparam int OPT_CAL_GATE     = 2;
    localparam int OPT_GLOBAL_OE    = 3;
    localparam int OPT_GLOBAL_CLR   = 4;
    localparam int OPT_SCLK_FROM_US = 5;
    localparam logic [OPT_W-1:0] OPT_RESET = 6'h00;

    // synchronised override bits
    localparam int SYNC_W      = 2;
    localparam int SYNC_OE     = 0;
    localparam int SYNC_CLR    = 1;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 2'h3;  // inactive levels

    // timing
    localparam int INIT_TICKS_DEF = 16;  // ticks of initialization: start-up clock edges with that option on, else fabric cycles
    localparam int SCLK_HALF_DEF  = 4;   // internal serial clock half period, cycles

endpackage

// file: rtl/ocp_sync_if.sv
`timescale 1ns/1ps
// raw override pins in, synchronised copies out
interface ocp_sync_if;
    import ocp_pkg::*;
    logic [SYNC_W-1:0] rawIn;
    logic [SYNC_W-1:0] syncOut;

    modport owner (
        output rawIn,
        input  syncOut
    );

    modport sync (
        input  rawIn,
        output syncOut
    );
endinterface

// file: rtl/ocp_sync.sv
`timescale 1ns/1ps
module ocp_sync (
    input  wire logic clk,
    input  wire logic nrst,
    ocp_sync_if.sync  port
);
    import ocp_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] stage1;
        logic [SYNC_W-1:0] stage2;
    } ocp_sync_s;

    ocp_sync_s state_q;
    ocp_sync_s state_d;

    // first stage feeds only the second one, so it never fans out metastable
    always_comb begin
        state_d        = state_q;
        state_d.stage1 = port.rawIn;
        state_d.stage2 = state_q.stage1;
    end

    // reset to the inactive pin levels
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= '{stage1: SYNC_RESET, stage2: SYNC_RESET};
        end else begin
            state_q <= state_d;
        end
    end

    assign port.syncOut = state_q.stage2;
endmodule

// file: rtl/ocp_pin_control.sv
`timescale 1ns/1ps
module ocp_pin_control #(
    parameter int INIT_TICKS = ocp_pkg::INIT_TICKS_DEF,
    parameter int SCLK_HALF  = ocp_pkg::SCLK_HALF_DEF
) (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    // configuration request pin, low restarts configuration
    input  wire logic                     configRequestN,
    // from the configuration sequencer
    input  wire logic                     activeSerialScheme,
    input  wire logic                     firstFrameValid,
    input  wire logic [ocp_pkg::OPT_W-1:0] firstFrameOptions,
    input  wire logic                     configDone,
    // from termination calibration
    input  wire logic                     terminationCalibrated,
    // optional pins
    input  wire logic                     startupClockIn,
    input  wire logic                     globalOutputEnable,
    input  wire logic                     globalClearN,
    output logic                          initDonePinOut,
    output logic                          initDonePinOeN,
    // user logic side of the pins when used as plain I/O
    input  wire logic                     userInitDoneOut,
    input  wire logic                     userInitDoneOeN,
    output logic                          userStartupPin,
    output logic                          userOutputEnablePin,
    output logic                          userClearPin,
    // device-wide effects
    output logic                          configSerialClock,
    output logic                          ioTristateAll,
    output logic                          registerClearAll,
    output logic                          userMode
);
    import ocp_pkg::*;

    localparam int CNT_W  = (INIT_TICKS > 1) ? $clog2(INIT_TICKS) : 1;
    localparam int DIV_W  = (SCLK_HALF > 1) ? $clog2(SCLK_HALF) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(INIT_TICKS - 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCLK_HALF - 1);

    typedef struct packed {
        ocp_state_e        fsm;
        logic [OPT_W-1:0]  opts;
        logic [CNT_W-1:0]  initCnt;
        logic [DIV_W-1:0]  divCnt;
        logic              startPrev;
        logic              sclk;
        logic              idOut;
        logic              idOeN;
        logic              usrStart;
        logic              usrOe;
        logic              usrClr;
        logic              triAll;
        logic              clrAll;
        logic              user;
    } ocp_state_s;

    ocp_state_s state_q;
    ocp_state_s state_d;

    ocp_sync_if syncPort ();

    // override pins are asynchronous to the fabric
    assign syncPort.rawIn = {globalClearN, globalOutputEnable};

    ocp_sync u_sync (
        .clk  (clk),
        .nrst (nrst),
        .port (syncPort)
    );

    // true while configuration data or initialization is in progress
    function automatic logic inConfig(input ocp_state_e s);
        inConfig = (s == OCP_CONFIG) || (s == OCP_INIT) || (s == OCP_CALWAIT);
    endfunction

    logic startEdge;
    logic initTick;
    logic calReady;
    logic oeOverride;
    logic clrOverride;
    logic sclkFromUser;

    // decoded conditions on the latched options
    always_comb begin
        startEdge    = startupClockIn && !state_q.startPrev;
        // user clock edges pace initialization, else every fabric cycle
        initTick     = state_q.opts[OPT_STARTUP_CLK] ? startEdge : 1'b1;
        // gating ignored when the option is off
        calReady     = !state_q.opts[OPT_CAL_GATE] || terminationCalibrated;
        oeOverride   = state_q.opts[OPT_GLOBAL_OE] && !syncPort.syncOut[SYNC_OE];
        clrOverride  = state_q.opts[OPT_GLOBAL_CLR] && !syncPort.syncOut[SYNC_CLR];
        sclkFromUser = activeSerialScheme && state_q.opts[OPT_SCLK_FROM_US]
                       && state_q.opts[OPT_STARTUP_CLK];
    end

    // sequencer, pin muxing and serial clock, all in one next-state copy
    always_comb begin
        state_d           = state_q;
        state_d.startPrev = startupClockIn;

        // configuration sequence
        case (state_q.fsm)
            OCP_IDLE: begin
                if (configRequestN) begin
                    state_d.fsm = OCP_LOAD;
                end
            end
            OCP_LOAD: begin
                // options arrive with the first frame only
                if (firstFrameValid) begin
                    state_d.opts = firstFrameOptions;
                    state_d.fsm  = OCP_CONFIG;
                end
            end
            OCP_CONFIG: begin
                if (configDone) begin
                    state_d.initCnt = '0;
                    state_d.fsm     = OCP_INIT;
                end
            end
            OCP_INIT: begin
                if (initTick) begin
                    if (state_q.initCnt == CNT_LAST) begin
                        state_d.fsm = calReady ? OCP_USER : OCP_CALWAIT;
                    end else begin
                        state_d.initCnt = state_q.initCnt + CNT_W'(1);
                    end
                end
            end
            OCP_CALWAIT: begin
                if (terminationCalibrated) begin
                    state_d.fsm = OCP_USER;
                end
            end
            OCP_USER: begin
                state_d.fsm = OCP_USER;
            end
            default: begin
                state_d.fsm = OCP_IDLE;
            end
        endcase

        // a low request aborts everything and forgets the options
        if (!configRequestN) begin
            state_d.fsm     = OCP_IDLE;
            state_d.opts    = OPT_RESET;
            state_d.initCnt = '0;
        end

        state_d.user = (state_d.fsm == OCP_USER);

        // serial clock: only toggles while configuration is under way
        if (state_q.fsm == OCP_LOAD || state_q.fsm == OCP_CONFIG) begin
            if (sclkFromUser) begin
                state_d.sclk   = startupClockIn;
                state_d.divCnt = '0;
            end else if (state_q.divCnt == DIV_LAST) begin
                state_d.divCnt = '0;
                state_d.sclk   = !state_q.sclk;
            end else begin
                state_d.divCnt = state_q.divCnt + DIV_W'(1);
            end
        end else begin
            state_d.sclk   = 1'b0;
            state_d.divCnt = '0;
        end

        // init-done pin: open drain when dedicated, low level or released; as plain user I/O it can drive high
        state_d.idOut = 1'b0;
        state_d.idOeN = 1'b1;
        if (state_d.opts[OPT_INIT_DONE]) begin
            // dedicated: pull low from option load until initialization ends
            state_d.idOeN = !inConfig(state_d.fsm);
        end else if (state_d.fsm == OCP_USER && !oeOverride) begin
            // plain user I/O, honoured only in user mode
            state_d.idOut = userInitDoneOut;
            state_d.idOeN = userInitDoneOeN;
        end
        if (state_d.fsm == OCP_IDLE) begin
            state_d.idOeN = 1'b1;
        end

        // input pins reach user logic only when their option is off
        state_d.usrStart = state_q.opts[OPT_STARTUP_CLK] ? 1'b0 : startupClockIn;
        state_d.usrOe    = state_q.opts[OPT_GLOBAL_OE] ? 1'b0 : globalOutputEnable;
        state_d.usrClr   = state_q.opts[OPT_GLOBAL_CLR] ? 1'b0 : globalClearN;

        // device-wide overrides act on the fabric, from the synced copies
        state_d.triAll = oeOverride;
        state_d.clrAll = clrOverride;
    end

    // one register for the whole block apart from the override synchronizer in u_sync
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= '{fsm:       OCP_IDLE,
                         opts:      OPT_RESET,
                         initCnt:   '0,
                         divCnt:    '0,
                         startPrev: 1'b0,
                         sclk:      1'b0,
                         idOut:     1'b0,
                         idOeN:     1'b1,
                         usrStart:  1'b0,
                         usrOe:     1'b0,
                         usrClr:    1'b0,
                         triAll:    1'b0,
                         clrAll:    1'b0,
                         user:      1'b0};
        end else begin
            state_q <= state_d;
        end
    end

    // every output straight from the register
    assign initDonePinOut      = state_q.idOut;
    assign initDonePinOeN      = state_q.idOeN;
    assign userStartupPin      = state_q.usrStart;
    assign userOutputEnablePin = state_q.usrOe;
    assign userClearPin        = state_q.usrClr;
    assign configSerialClock   = state_q.sclk;
    assign ioTristateAll       = state_q.triAll;
    assign registerClearAll    = state_q.clrAll;
    assign userMode            = state_q.user;
endmodule

// file: tb/ocp_pin_control_asserts.sv
`timescale 1ns/1ps
module ocp_pin_control_asserts
    import ocp_pkg::*;
(
    input wire logic             clk,
    input wire logic             nrst,
    input wire logic             configRequestN,
    input wire logic             firstFrameValid,
    input wire logic [OPT_W-1:0] firstFrameOptions,
    input wire logic             terminationCalibrated,
    input wire logic             globalOutputEnable,
    input wire logic             globalClearN,
    input wire logic             initDonePinOut,
    input wire logic             initDonePinOeN,
    input wire logic             ioTristateAll,
    input wire logic             registerClearAll,
    input wire logic             userMode
);
    logic [OPT_W-1:0] optQ;
    // shadow of the latched options; frames outside load are never sent
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            optQ <= OPT_RESET;
        else if (!configRequestN)
            optQ <= OPT_RESET;
        else if (firstFrameValid)
            optQ <= firstFrameOptions;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_frame_on;
        firstFrameValid && firstFrameOptions[OPT_INIT_DONE];
    endsequence
    sequence s_drive_low;
        !initDonePinOeN && !initDonePinOut;
    endsequence
    a_frame_drive: assert property (s_frame_on |=> s_drive_low)
        else $error("init pin not pulled low after frame");
    a_abort_float: assert property (!configRequestN |=> initDonePinOeN && !userMode)
        else $error("init pin driven during request");
    a_never_high: assert property (!initDonePinOeN && !userMode |-> !initDonePinOut)
        else $error("init pin driven high");
    a_user_release: assert property ($rose(userMode) && optQ[OPT_INIT_DONE] |-> initDonePinOeN)
        else $error("init pin held at user mode");
    a_cal_gate: assert property ($rose(userMode) && $past(optQ[OPT_CAL_GATE]) |-> $past(terminationCalibrated))
        else $error("user mode before calibration");
    a_oe_override: assert property (optQ[OPT_GLOBAL_OE] && $past(optQ[OPT_GLOBAL_OE])
        |-> ioTristateAll == !$past(globalOutputEnable, 3))
        else $error("tristate override wrong");
    a_oe_unused: assert property (!$past(optQ[OPT_GLOBAL_OE]) |-> !ioTristateAll)
        else $error("tristate without option");
    a_clr_override: assert property (optQ[OPT_GLOBAL_CLR] && $past(optQ[OPT_GLOBAL_CLR])
        |-> registerClearAll == !$past(globalClearN, 3))
        else $error("clear override wrong");
endmodule

bind ocp_pin_control ocp_pin_control_asserts chk (.clk, .nrst, .configRequestN, .firstFrameValid,
    .firstFrameOptions, .terminationCalibrated, .globalOutputEnable, .globalClearN, .initDonePinOut,
    .initDonePinOeN, .ioTristateAll, .registerClearAll, .userMode);

// file: tb/ocp_board_model.sv
`timescale 1ns/1ps
module ocp_board_model (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic pinOut,
    input  wire logic pinOeN,
    input  wire logic ovrReq,
    output logic      initWire,
    output logic      userSeen,
    output logic      devOe,
    output logic      devClrN
);
    logic prevQ;
    // board pull-up holds the open-drain line high when undriven
    assign initWire = pinOeN ? 1'h1 : pinOut;
    // a rise on the line marks user mode; overrides are board-timed
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prevQ <= 1'h1;
            userSeen <= 1'h0;
            devOe <= 1'h1;
            devClrN <= 1'h1;
        end else begin
            prevQ <= initWire;
            userSeen <= initWire && (userSeen || !prevQ);
            devOe <= !ovrReq;
            devClrN <= !ovrReq;
        end
    end
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
    import ocp_pkg::*;
    typedef struct {logic [OPT_W-1:0] o; logic t; logic u;} ocp_row_s;
    ocp_row_s rows [5] = '{'{6'h02, 1'h0, 1'h1}, '{6'h06, 1'h0, 1'h0}, '{6'h06, 1'h1, 1'h1},
                           '{6'h00, 1'h0, 1'h1}, '{6'h1A, 1'h1, 1'h1}};
    logic clk = 1'h0, nrst = 1'h0, configRequestN = 1'h0, activeSerialScheme = 1'h0;
    logic firstFrameValid = 1'h0, configDone = 1'h0, terminationCalibrated = 1'h0;
    logic startupClockIn = 1'h0, userInitDoneOut = 1'h1, userInitDoneOeN = 1'h0, ovrReq = 1'h0;
    logic [OPT_W-1:0] firstFrameOptions = 6'h00;
    logic globalOutputEnable, globalClearN, initDonePinOut, initDonePinOeN, userStartupPin;
    logic userOutputEnablePin, userClearPin, configSerialClock, ioTristateAll, registerClearAll;
    logic userMode, initWire, userSeen;
    int   fails = 0, checks_done = 0;
    ocp_pin_control #(.INIT_TICKS(2), .SCLK_HALF(1)) dut (.clk, .nrst, .configRequestN,
        .activeSerialScheme, .firstFrameValid, .firstFrameOptions, .configDone, .terminationCalibrated,
        .startupClockIn, .globalOutputEnable, .globalClearN, .initDonePinOut, .initDonePinOeN,
        .userInitDoneOut, .userInitDoneOeN, .userStartupPin, .userOutputEnablePin, .userClearPin,
        .configSerialClock, .ioTristateAll, .registerClearAll, .userMode);
    ocp_board_model board (.clk, .nrst, .pinOut(initDonePinOut), .pinOeN(initDonePinOeN), .ovrReq,
        .initWire, .userSeen, .devOe(globalOutputEnable), .devClrN(globalClearN));
    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task chk(input logic g, input logic e, input string m);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("Error %0t: %s", $time, m);
        end
    endtask
    // abort, then load one frame; checks the pin before and after
    task start(input logic [OPT_W-1:0] o, input logic t);
        configRequestN <= 1'h0;
        terminationCalibrated <= t;
        cyc(2);
        chk(initWire, 1'h1, "line low in abort");
        configRequestN <= 1'h1;
        cyc(1);
        firstFrameValid <= 1'h1;
        firstFrameOptions <= o;
        cyc(1);
        firstFrameValid <= 1'h0;
        cyc(1);
        chk(initDonePinOeN, ~o[OPT_INIT_DONE], "frame pin");
    endtask
    // bounded wait: a gated run without calibration must not reach user mode
    task finish(input logic e);
        configDone <= 1'h1;
        cyc(1);
        configDone <= 1'h0;
        for (int i = 0; i < 30 && userMode !== 1'h1; i++)
            cyc(1);
        chk(userMode, e, "user mode");
    endtask
    task final_report;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        cyc(2);
        nrst <= 1'h1;
        cyc(1);
        chk(initDonePinOeN, 1'h1, "reset pin");
        foreach (rows[k]) begin
            start(rows[k].o, rows[k].t);
            finish(rows[k].u);
            terminationCalibrated <= 1'h1;
            cyc(3);
            chk(userMode, 1'h1, "gate release");
            chk(initDonePinOeN, rows[k].o[OPT_INIT_DONE], "user pin");
            chk(initDonePinOut, ~rows[k].o[OPT_INIT_DONE], "user pin level");
            if (rows[k].o[OPT_INIT_DONE])
                chk(userSeen, 1'h1, "no rise seen");
            ovrReq <= 1'h1;
            cyc(5);
            chk(ioTristateAll, rows[k].o[OPT_GLOBAL_OE], "oe low");
            chk(registerClearAll, rows[k].o[OPT_GLOBAL_CLR], "clr low");
            ovrReq <= 1'h0;
            cyc(5);
            chk(ioTristateAll, 1'h0, "oe high");
            chk(userOutputEnablePin, ~rows[k].o[OPT_GLOBAL_OE], "oe user");
            chk(userClearPin, ~rows[k].o[OPT_GLOBAL_CLR], "clr user");
            $display("row %0d done", k);
        end
        // cycle gaps of 3 then 4 defeat a free-running divider
        activeSerialScheme <= 1'h1;
        start(6'h23, 1'h1);
        startupClockIn <= 1'h1;
        cyc(3);
        chk(configSerialClock, 1'h1, "sclk high");
        chk(userStartupPin, 1'h0, "start pin hidden");
        startupClockIn <= 1'h0;
        cyc(4);
        chk(configSerialClock, 1'h0, "sclk low");
        finish(1'h0);
        repeat (2) begin
            startupClockIn <= 1'h1;
            cyc(2);
            startupClockIn <= 1'h0;
            cyc(2);
        end
        cyc(3);
        chk(userMode, 1'h1, "ticks");
        $display("startup clock done");
        nrst <= 1'h0;
        cyc(2);
        chk(userMode, 1'h0, "mid reset");
        nrst <= 1'h1;
        startupClockIn <= 1'h1;
        cyc(1);
        chk(initDonePinOeN, 1'h1, "pin after reset");
        cyc(1);
        chk(userStartupPin, 1'h1, "start pin as user I/O");
        chk(userMode, 1'h0, "no user mode after reset");
        final_report;
    end
endmodule
